// File: shared/bmcs_consts.vh
// Constants for the boot mode and clock setup block
`ifndef BMCS_CONSTS_VH
`define BMCS_CONSTS_VH
`define BMCS_MODE_HOST_BUS_A 4'h1
`define BMCS_MODE_HOST_BUS_B 4'h2
`define BMCS_MODE_EXT_BUS 4'h4
`define BMCS_MODE_I2C 4'h5
`define BMCS_MODE_SPI16 4'h6
`define BMCS_MODE_NAND 4'h7
`define BMCS_MODE_UART 4'h8
`define BMCS_MODE_EXT_FAST 4'h9
`define BMCS_MODE_UART_FLOW 4'hE
`define BMCS_MODE_SPI24 4'hF
`define BMCS_ADDR_CS2 32'h42000000
`define BMCS_ADDR_ROM 32'h00100000
`define BMCS_PINOUT_ASYNC 3'h2
`define BMCS_PINOUT_NAND 3'h5
`define BMCS_I2C_PRESCALE 8'h02
`define BMCS_SCL_FAST 8'h08
`define BMCS_SCL_STD 8'h2D
`define BMCS_UART_DIVISOR 16'h000F
`define BMCS_UART_OVERSAMPLE 5'h10
`define BMCS_SERIAL_CLK_DIV 8'h02
`define BMCS_CORE_POSTDIV 3'h2
`define BMCS_PERIPH_DIV 4'h6
`define BMCS_MULT_BYPASS 5'h01
`define BMCS_CFG_MODE_LSB 0
`define BMCS_CFG_QUICK_BIT 4
`define BMCS_CFG_HOSTEN_BIT 5
`define BMCS_CFG_MULT_LSB 6
`define BMCS_CFG_PINOUT_LSB 9
`endif

// File: core/bmcs_mult_lut.v
// Multiplier lookup for the quick start PLL select pins
`timescale 1ns/1ps
module bmcs_mult_lut (
  input wire [2:0] mult_select_pins,
  output reg [4:0] mult
);
  // *****************************************
  // Pin code to PLL multiplier
  // *****************************************
  always @* begin
    case (mult_select_pins)
      3'h0: mult = 5'h14;
      3'h1: mult = 5'h0F;
      3'h2: mult = 5'h10;
      3'h3: mult = 5'h12;
      3'h4: mult = 5'h16;
      3'h5: mult = 5'h19;
      3'h6: mult = 5'h1B;
      3'h7: mult = 5'h1E;
      default: mult = 5'h14;
    endcase
  end
endmodule // bmcs_mult_lut

// File: core/bmcs_boot_setup.v
// Boot configuration capture and clock/divider settings per boot source
`timescale 1ns/1ps
`include "bmcs_consts.vh"
// Function
// RULE1: Ext-bus direct boot: fetch at 0x42000000, PLL bypass, async bus.
// RULE2: Board straps pinout select to 010b for direct external-bus boots.
// RULE3: Ext-bus quick start: start in ROM, PLL mode, image script from chip select 2.
// RULE4: Mode 1001b quick start: PLL mode from ROM, then fetch at 0x42000000.
// RULE5: NAND boot reads image script; pinout 010b or 101b; PLL only if quick.
// RULE6: I2C boot standard mode when quick clear, fast mode when set.
// RULE7: Fast I2C: prescale 2, SCL low and high counts 8.
// RULE8: Standard I2C: prescale 2, SCL low and high counts 45.
// RULE9: Board keeps reference clock 21 to 30 MHz for I2C boot.
// RULE10: UART boot: divisor 15, sixteen-times oversampling.
// RULE11: Both SPI boots use buffered serial port, serial clock divider 2.
// RULE12: Peripheral clock is core clock divided by six during boot.
// RULE13: Host-bus boot only with quick start; host-port boot either way.
// RULE14: Host sizes strobe inactive width to peripheral clock rate.
// RULE15: Designer keeps PLL output and core clock within limits.
// RULE16: Quick start multiplier from select pins; core clock is ref times mult over two.
// RULE17: After pin reset the PLL comes up in bypass.
// RULE18: Config pins captured at reset release into a read-only config word.
// RULE19: Latched settings hold until the next reset.
module bmcs_boot_setup (
  input wire clk,
  input wire rstn,
  input wire [3:0] boot_source_sel,
  input wire quick_start_sel,
  input wire host_bus_enable_pin,
  input wire [2:0] mult_select_pins,
  input wire [2:0] ext_bus_pinout_sel,
  input wire pll_locked,
  output reg cfg_valid,
  output reg [11:0] boot_cfg_word,
  output reg [31:0] boot_vector,
  output reg pll_mode_en,
  output reg [4:0] pll_mult,
  output reg [2:0] core_postdiv,
  output reg [3:0] periph_div,
  output reg ext_bus_async,
  output reg ext_bus_nand,
  output reg image_script_format,
  output reg jump_to_cs2,
  output reg i2c_en,
  output reg i2c_fast,
  output reg [7:0] i2c_prescale_field,
  output reg [7:0] scl_low_count,
  output reg [7:0] scl_high_count,
  output reg uart_en,
  output reg uart_flow_ctrl,
  output reg [15:0] uart_divisor,
  output reg [4:0] uart_oversample,
  output reg spi_en,
  output reg spi_addr24,
  output reg [7:0] serial_clk_divider,
  output reg host_boot_en,
  output reg host_bus_boot,
  output reg pinout_error,
  output reg mode_error,
  output reg boot_go
);
  // *****************************************
  // Pin synchronisers and capture
  // *****************************************
  reg [11:0] pin_meta;
  reg [11:0] pin_sync;
  reg [1:0] rel_cnt;
  wire [4:0] lut_mult;
  wire [3:0] mode = boot_cfg_word[`BMCS_CFG_MODE_LSB +: 4];
  wire quick = boot_cfg_word[`BMCS_CFG_QUICK_BIT];
  wire host_en = boot_cfg_word[`BMCS_CFG_HOSTEN_BIT];
  wire [2:0] pinout = boot_cfg_word[`BMCS_CFG_PINOUT_LSB +: 3];

  // Two-stage sync of the strap pins
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= 12'h000;
      pin_sync <= 12'h000;
    end else begin
      pin_meta <= {ext_bus_pinout_sel, mult_select_pins, host_bus_enable_pin, quick_start_sel, boot_source_sel};
      pin_sync <= pin_meta;
    end
  end

  // Capture once the sync chain has filled after release, then hold
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rel_cnt <= 2'h0;
      cfg_valid <= 1'b0;
      boot_cfg_word <= 12'h000;
    end else if (!cfg_valid) begin
      if (rel_cnt == 2'h2) begin
        boot_cfg_word <= pin_sync; // RULE18
        cfg_valid <= 1'b1; // RULE19
      end else begin
        rel_cnt <= rel_cnt + 2'h1;
      end
    end
  end

  bmcs_mult_lut u_lut (
    .mult_select_pins(boot_cfg_word[`BMCS_CFG_MULT_LSB +: 3]),
    .mult(lut_mult)
  );

  // *****************************************
  // Decode of boot source into settings
  // *****************************************
  reg [31:0] next_vector;
  reg next_pll, next_async, next_nand, next_ais, next_jump;
  reg next_i2c, next_uart, next_flow, next_spi, next_spi24, next_host, next_hbus;
  reg next_perr, next_merr;

  // Combinational decode of the latched word
  always @* begin
    next_vector = `BMCS_ADDR_ROM;
    next_pll = quick; // RULE5
    next_async = 1'b0;
    next_nand = 1'b0;
    next_ais = 1'b0;
    next_jump = 1'b0;
    next_i2c = 1'b0;
    next_uart = 1'b0;
    next_flow = 1'b0;
    next_spi = 1'b0;
    next_spi24 = 1'b0;
    next_host = 1'b0;
    next_hbus = 1'b0;
    next_perr = 1'b0;
    next_merr = 1'b0;
    case (mode)
      `BMCS_MODE_EXT_BUS: begin
        next_async = 1'b1;
        next_perr = (pinout != `BMCS_PINOUT_ASYNC); // RULE2
        if (!quick) begin
          next_vector = `BMCS_ADDR_CS2; // RULE1
        end else begin
          next_ais = 1'b1; // RULE3
        end
      end
      `BMCS_MODE_EXT_FAST: begin
        next_async = 1'b1;
        next_jump = quick; // RULE4
        next_merr = !quick;
        next_perr = (pinout != `BMCS_PINOUT_ASYNC);
      end
      `BMCS_MODE_NAND: begin
        next_nand = 1'b1;
        next_ais = 1'b1; // RULE5
        next_perr = (pinout != `BMCS_PINOUT_ASYNC) && (pinout != `BMCS_PINOUT_NAND); // RULE5
      end
      `BMCS_MODE_I2C: next_i2c = 1'b1; // RULE6
      `BMCS_MODE_UART: next_uart = 1'b1; // RULE10
      `BMCS_MODE_UART_FLOW: begin
        next_uart = 1'b1;
        next_flow = 1'b1;
      end
      `BMCS_MODE_SPI16: next_spi = 1'b1; // RULE11
      `BMCS_MODE_SPI24: begin
        next_spi = 1'b1;
        next_spi24 = 1'b1;
      end
      `BMCS_MODE_HOST_BUS_A, `BMCS_MODE_HOST_BUS_B: begin
        next_host = 1'b1;
        if (host_en) begin
          next_hbus = quick; // RULE13
          next_merr = !quick; // RULE13
        end
      end
      default: next_merr = 1'b0;
    endcase
  end

  // *****************************************
  // Settings registers
  // *****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_vector <= `BMCS_ADDR_ROM;
      pll_mode_en <= 1'b0; // RULE17
      pll_mult <= `BMCS_MULT_BYPASS;
      core_postdiv <= `BMCS_CORE_POSTDIV;
      periph_div <= `BMCS_PERIPH_DIV;
      ext_bus_async <= 1'b0;
      ext_bus_nand <= 1'b0;
      image_script_format <= 1'b0;
      jump_to_cs2 <= 1'b0;
      i2c_en <= 1'b0;
      i2c_fast <= 1'b0;
      i2c_prescale_field <= 8'h00;
      scl_low_count <= 8'h00;
      scl_high_count <= 8'h00;
      uart_en <= 1'b0;
      uart_flow_ctrl <= 1'b0;
      uart_divisor <= 16'h0000;
      uart_oversample <= 5'h00;
      spi_en <= 1'b0;
      spi_addr24 <= 1'b0;
      serial_clk_divider <= 8'h00;
      host_boot_en <= 1'b0;
      host_bus_boot <= 1'b0;
      pinout_error <= 1'b0;
      mode_error <= 1'b0;
      boot_go <= 1'b0;
    end else if (cfg_valid && !boot_go) begin
      boot_vector <= next_vector;
      pll_mode_en <= next_pll; // RULE3
      pll_mult <= next_pll ? lut_mult : `BMCS_MULT_BYPASS; // RULE16
      core_postdiv <= `BMCS_CORE_POSTDIV; // RULE16
      periph_div <= `BMCS_PERIPH_DIV; // RULE12
      ext_bus_async <= next_async;
      ext_bus_nand <= next_nand;
      image_script_format <= next_ais;
      jump_to_cs2 <= next_jump;
      i2c_en <= next_i2c;
      i2c_fast <= next_i2c & quick; // RULE6
      i2c_prescale_field <= next_i2c ? `BMCS_I2C_PRESCALE : 8'h00;
      scl_low_count <= !next_i2c ? 8'h00 : (quick ? `BMCS_SCL_FAST : `BMCS_SCL_STD); // RULE7
      scl_high_count <= !next_i2c ? 8'h00 : (quick ? `BMCS_SCL_FAST : `BMCS_SCL_STD); // RULE8
      uart_en <= next_uart;
      uart_flow_ctrl <= next_flow;
      uart_divisor <= next_uart ? `BMCS_UART_DIVISOR : 16'h0000; // RULE10
      uart_oversample <= next_uart ? `BMCS_UART_OVERSAMPLE : 5'h00; // RULE10
      spi_en <= next_spi;
      spi_addr24 <= next_spi24;
      serial_clk_divider <= next_spi ? `BMCS_SERIAL_CLK_DIV : 8'h00; // RULE11
      host_boot_en <= next_host & !next_merr;
      host_bus_boot <= next_hbus;
      pinout_error <= next_perr;
      mode_error <= next_merr;
      // Quick start waits for lock before handing over
      boot_go <= !next_pll || pll_locked; // RULE4
    end
  end
endmodule // bmcs_boot_setup

// File: tb/bmcs_pll_model.sv
// Model of the system PLL lock response seen by the boot setup block
`timescale 1ns/1ps
module bmcs_pll_model #(
  parameter LOCK_CYC = 6
) (
  input wire clk,
  input wire rstn,
  input wire pll_mode_en,
  output reg pll_locked
);
  integer cnt;
  // Lock only after the PLL has run in PLL mode for a while; bypass never locks
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      pll_locked <= 1'b0;
    end else if (!pll_mode_en) begin
      cnt <= 0;
      pll_locked <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      pll_locked <= (cnt >= LOCK_CYC - 1);
    end
  end
endmodule // bmcs_pll_model

// File: tb/bmcs_boot_setup_assertions.sv
// Assertions on the boot setup block ports
`timescale 1ns/1ps
`include "bmcs_consts.vh"
module bmcs_boot_setup_assertions (
  input wire clk, input wire rstn, input wire cfg_valid, input wire boot_go,
  input wire [11:0] boot_cfg_word, input wire [31:0] boot_vector, input wire pll_mode_en,
  input wire [4:0] pll_mult, input wire [2:0] core_postdiv, input wire [3:0] periph_div,
  input wire ext_bus_async, input wire i2c_fast, input wire [7:0] i2c_prescale_field,
  input wire [7:0] scl_low_count, input wire [7:0] scl_high_count, input wire uart_en,
  input wire [15:0] uart_divisor, input wire [4:0] uart_oversample, input wire spi_en,
  input wire [7:0] serial_clk_divider
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire [3:0] md = boot_cfg_word[3:0];
  wire qk = boot_cfg_word[4];
  // Per-mode settings once boot is released, PLL bypass before capture, and a held config word
  property p_direct; boot_go && md == `BMCS_MODE_EXT_BUS && !qk |->
    boot_vector == `BMCS_ADDR_CS2 && !pll_mode_en && ext_bus_async; endproperty
  a_direct: assert property (p_direct) else $error("bad direct boot");
  property p_rom; boot_go && md == `BMCS_MODE_EXT_BUS && qk |-> boot_vector == `BMCS_ADDR_ROM && pll_mode_en; endproperty
  a_rom: assert property (p_rom) else $error("bad rom start");
  property p_i2c; boot_go && md == `BMCS_MODE_I2C |-> i2c_fast == qk && i2c_prescale_field == 8'h02 &&
    scl_low_count == (qk ? 8'h08 : 8'h2D) && scl_high_count == scl_low_count; endproperty
  a_i2c: assert property (p_i2c) else $error("bad i2c setup");
  property p_uart; boot_go && uart_en |-> uart_divisor == 16'h000F && uart_oversample == 5'h10; endproperty
  a_uart: assert property (p_uart) else $error("bad uart setup");
  property p_spi; boot_go && spi_en |-> serial_clk_divider == 8'h02; endproperty
  a_spi: assert property (p_spi) else $error("bad spi setup");
  property p_div; boot_go |-> periph_div == 4'h6 && core_postdiv == 3'h2; endproperty
  a_div: assert property (p_div) else $error("bad clock dividers");
  property p_bypass; !cfg_valid |-> !pll_mode_en && pll_mult == 5'h01 [*2]; endproperty
  a_bypass: assert property (p_bypass) else $error("pll not in bypass");
  property p_hold; $past(cfg_valid) && cfg_valid |-> $stable(boot_cfg_word); endproperty
  a_hold: assert property (p_hold) else $error("config word moved");
  c_i2c: cover property (boot_go && i2c_fast);
  c_spi: cover property (boot_go && spi_en);
  c_pll: cover property (boot_go && pll_mode_en);
endmodule // bmcs_boot_setup_assertions
bind bmcs_boot_setup bmcs_boot_setup_assertions bmcs_boot_setup_assertions_inst (.clk, .rstn, .cfg_valid,
  .boot_go, .boot_cfg_word, .boot_vector, .pll_mode_en, .pll_mult, .core_postdiv, .periph_div, .ext_bus_async,
  .i2c_fast, .i2c_prescale_field, .scl_low_count, .scl_high_count, .uart_en, .uart_divisor, .uart_oversample,
  .spi_en, .serial_clk_divider);

// File: tb/bmcs_boot_setup_tb_top.sv
// Testbench for the boot setup block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module bmcs_boot_setup_tb_top;
  reg clk = 0, rstn = 0, quick_start_sel = 0, host_bus_enable_pin = 0;
  reg [3:0] boot_source_sel = 0;
  reg [2:0] mult_select_pins = 0, ext_bus_pinout_sel = 0;
  wire pll_locked, pll_mode_en, ext_bus_async, ext_bus_nand, image_script_format, jump_to_cs2, i2c_fast;
  wire uart_flow_ctrl, spi_en, spi_addr24, host_boot_en, host_bus_boot, pinout_error, mode_error, boot_go;
  wire i2c_en, uart_en;
  wire [3:0] periph_div;
  wire [7:0] i2c_prescale_field;
  wire [11:0] boot_cfg_word;
  wire [31:0] boot_vector;
  wire [4:0] pll_mult;
  wire [7:0] scl_low_count, serial_clk_divider;
  wire [15:0] uart_divisor;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  int mt[8] = '{20, 15, 16, 18, 22, 25, 27, 30};
  bmcs_boot_setup bmcs_boot_setup_inst (.clk, .rstn, .boot_source_sel, .quick_start_sel, .host_bus_enable_pin,
    .mult_select_pins, .ext_bus_pinout_sel, .pll_locked, .cfg_valid(), .boot_cfg_word, .boot_vector, .pll_mode_en,
    .pll_mult, .core_postdiv(), .periph_div, .ext_bus_async, .ext_bus_nand, .image_script_format, .jump_to_cs2,
    .i2c_en, .i2c_fast, .i2c_prescale_field, .scl_low_count, .scl_high_count(), .uart_en, .uart_flow_ctrl,
    .uart_divisor, .uart_oversample(), .spi_en, .spi_addr24, .serial_clk_divider, .host_boot_en, .host_bus_boot,
    .pinout_error, .mode_error, .boot_go);
  bmcs_pll_model #(.LOCK_CYC(6)) bmcs_pll_model_inst (.clk, .rstn, .pll_mode_en, .pll_locked);
  // Clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Apply straps under a 10-cycle reset, release and wait for boot release
  task automatic boot(input [3:0] m, input q, input h, input [2:0] ms, input [2:0] pn);
    int i;
    @(negedge clk);
    rstn = 0;
    {boot_source_sel, quick_start_sel, host_bus_enable_pin, mult_select_pins, ext_bus_pinout_sel} = {m, q, h, ms, pn};
    repeat (10) @(negedge clk);
    rstn = 1;
    for (i = 0; i < 40 && boot_go !== 1'b1; i++) @(negedge clk);
    `CHK("boot_go", 1'b1, boot_go)
  endtask
  task automatic t_ext;
    boot(4'h4, 0, 0, 3'h0, 3'h2);
    `CHK("vector", 32'h42000000, boot_vector)
    `CHK("pll_mult", 5'h01, pll_mult)
    `CHK("pinout_err", 1'b0, pinout_error)
    boot(4'h4, 0, 0, 3'h0, 3'h5);
    `CHK("pinout_err", 1'b1, pinout_error)
    boot(4'h9, 1, 0, 3'h0, 3'h2);
    `CHK("jump_cs2", 1'b1, jump_to_cs2)
    boot(4'h7, 0, 0, 3'h0, 3'h5);
    `CHK("nand", 3'b110, {ext_bus_nand, image_script_format, pll_mode_en})
    // Mode 1001b without quick start is refused with a mode error
    boot(4'h9, 0, 0, 3'h0, 3'h2);
    `CHK("ext_fast_slow", 3'b010, {jump_to_cs2, mode_error, pll_mode_en})
  endtask
  task automatic t_quick;
    for (int k = 0; k < 8; k++) begin
      boot(4'h4, 1, 0, k[2:0], 3'h2);
      `CHK("pll_mult", 5'(mt[k]), pll_mult)
      `CHK("rom_ais", 2'b11, {image_script_format, pll_mode_en})
    end
    @(negedge clk);
    boot_source_sel = 4'hF;
    repeat (5) @(negedge clk);
    `CHK("cfg_word", {3'h2, 3'h7, 1'b0, 1'b1, 4'h4}, boot_cfg_word)
  endtask
  task automatic t_serial;
    for (int q = 0; q < 2; q++) begin
      boot(4'h5, q[0], 0, 3'h0, 3'h2);
      `CHK("i2c", {q[0], q[0] ? 8'h08 : 8'h2D}, {i2c_fast, scl_low_count})
      `CHK("i2c_en", 1'b1, i2c_en)
      // Prescale of 2 gives the reference over three; the board keeps that in range
      `CHK("i2c_psc", 8'h02, i2c_prescale_field)
    end
    boot(4'hE, 0, 0, 3'h0, 3'h2);
    `CHK("uart", {1'b1, 16'h000F}, {uart_flow_ctrl, uart_divisor})
    boot(4'h8, 0, 0, 3'h0, 3'h2);
    `CHK("uart_noflow", {2'b10, 16'h000F}, {uart_en, uart_flow_ctrl, uart_divisor})
    boot(4'h6, 0, 0, 3'h0, 3'h2);
    `CHK("spi16", {2'b10, 8'h02}, {spi_en, spi_addr24, serial_clk_divider})
    boot(4'hF, 1, 0, 3'h1, 3'h2);
    `CHK("spi", {2'b11, 8'h02}, {spi_en, spi_addr24, serial_clk_divider})
  endtask
  task automatic t_host;
    boot(4'h1, 0, 1, 3'h0, 3'h2);
    `CHK("host_bus_slow", 2'b01, {host_boot_en, mode_error})
    boot(4'h2, 1, 1, 3'h0, 3'h2);
    `CHK("host_bus_fast", 2'b11, {host_boot_en, host_bus_boot})
    boot(4'h1, 0, 0, 3'h0, 3'h2);
    `CHK("host_port", 2'b10, {host_boot_en, mode_error})
    // The host times its strobe from the peripheral clock ratio
    `CHK("periph_div", 4'h6, periph_div)
    // Reserved code: ROM start, every boot path off, no error flag
    boot(4'hB, 0, 0, 3'h0, 3'h2);
    `CHK("rsv_vector", 32'h00100000, boot_vector)
    `CHK("rsv_off", 5'h00, {mode_error, i2c_en, uart_en, spi_en, host_boot_en})
  endtask
  initial begin
    t_ext;
    t_quick;
    t_serial;
    t_host;
    print_verdict;
  end
endmodule // bmcs_boot_setup_tb_top
